// ===== core/serial_unit.sv
// Serial peripheral unit: APB registers, word FIFOs, shift engine.
// Assumes pins are synchronised here; sck and ss pins are two-way.
//
// Behaviour
// - Slave always samples input at mid data time, ignoring phase bit.
// - Edge bit 1 shifts output on active-to-idle, 0 on idle-to-active.
// - Slave-select enable makes slave use select pin; else pin is free.
// - Polarity 1 idles clock high, 0 idles clock low.
// - Master enable selects master operation, cleared selects slave.
// - Transmit interrupt: not full, half empty, empty, or all done.
// - Receive interrupt: full, half full, not empty, or emptied.
// - Status reports five-bit receive and transmit element counts.
// - Busy bit reads 1 during a transaction, 0 when idle.
// - Underrun set only in framed mode; cleared only by disabling.
// - Shifter-empty flag reads 1 while shift register holds nothing.
// - Overflow set on discarded word; only software writing 0 clears.
// - Receive empty flag is 1 when read and write pointers match.
// - Transmit empty set on move to shifter, cleared on data write.
// - Transmit full: write sets, move clears; enhanced wp+1 equals rp.
// - Standard receive full set on move in, cleared on data read.
// - Enhanced receive full is set exactly when wp+1 equals rp.
// - Word width 32 if 32 select, else 16 if 16 select, else 8.
// - Enhanced enable switches single word buffer to FIFO.
// - Framed enable makes a master drive select pin as frame sync.
// - Unit enable bit turns the whole unit on or off.
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/10ps
module serial_unit import spi_pkg::*; #(
  parameter int DEPTH = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe_n,
  input  wire logic        sdi_i,
  output logic             sdo_o,
  input  wire logic        ss_i,
  output logic             ss_o,
  output logic             ss_oe_n,
  output logic             tx_irq,
  output logic             rx_irq
);
  localparam int AW = $clog2(DEPTH);

  function automatic logic [5:0] nbits_f(input logic m32, input logic m16);
    nbits_f = m32 ? 6'd32 : (m16 ? 6'd16 : 6'd8);
  endfunction

  function automatic logic [31:0] mask_f(input logic [5:0] n);
    mask_f = (n == 6'd32) ? 32'hffff_ffff : ((32'h1 << n) - 32'h1);
  endfunction

  logic [31:0] ctrl_r;
  logic [8:0]  baud_r;
  logic [31:0] tx_mem [DEPTH];
  logic [31:0] rx_mem [DEPTH];
  logic [AW-1:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
  logic [AW-1:0] tx_cnt, rx_cnt;
  logic [AW:0]   cap, tx_free;
  logic [2:0]  s1_r, s2_r, s3_r, f_r;
  logic        sck_d_r;
  logic        busy_r, loaded_r, pend_r, tur_r, ovf_r;
  logic [31:0] sr_r, rsh_r;
  logic [5:0]  bit_r;
  logic [6:0]  half_r;
  logic [8:0]  div_r;
  logic        on, mst, clock_polarity, cke, enh, frm, slave_select_enable;
  logic [5:0]  nb;
  logic        tx_full, tx_empty, rx_full, rx_empty;
  logic        acc, wr_data, rd_data, wr_ctrl, wr_stat;
  logic        tx_push, rx_pop, rx_push, ovf_set;
  logic        tick, last, sel, s_edge, start, act;
  logic        e_lead, e_trail, e_launch, e_mid, sample, done;
  logic        load, mstart;
  logic [31:0] rx_word, stat, ld_word;

  // ****************
  // Control decode
  // ****************
  assign on   = ctrl_r[C_ON];
  assign mst  = ctrl_r[C_MST];
  assign clock_polarity  = ctrl_r[C_CKP];
  assign cke  = ctrl_r[C_CKE];
  assign enh  = ctrl_r[C_ENH];
  assign frm  = ctrl_r[C_FRM];
  assign slave_select_enable = ctrl_r[C_SLAVE_SELECT_ENABLE];
  assign nb   = nbits_f(ctrl_r[C_M32], ctrl_r[C_M16]);

  // ****************
  // FIFO flags
  // ****************
  assign cap      = enh ? (AW+1)'(DEPTH - 1) : (AW+1)'(1);
  assign tx_cnt   = tx_wp_r - tx_rp_r;
  assign rx_cnt   = rx_wp_r - rx_rp_r;
  assign tx_free  = cap - (AW+1)'(tx_cnt);
  assign tx_empty = (tx_cnt == '0);
  assign rx_empty = (rx_wp_r == rx_rp_r);
  assign tx_full  = enh ? (tx_wp_r + 1'b1 == tx_rp_r)
                        : (tx_cnt != '0);
  assign rx_full  = enh ? (rx_wp_r + 1'b1 == rx_rp_r)
                        : (rx_cnt != '0);

  // ****************
  // APB decode
  // ****************
  assign acc     = psel & penable & pready;
  assign wr_data = acc & pwrite & (paddr == DATA_OFS);
  assign rd_data = acc & ~pwrite & (paddr == DATA_OFS);
  assign wr_ctrl = acc & pwrite & (paddr == CTRL_OFS);
  assign wr_stat = acc & pwrite & (paddr == STAT_OFS);
  assign tx_push = wr_data & on & ~tx_full;
  assign rx_pop  = rd_data & on & ~rx_empty;

  // ****************
  // Edge events
  // ****************
  assign tick   = mst & busy_r & (div_r == '0);
  assign last   = tick & (half_r == 7'({nb, 1'b0} - 7'd1));
  assign sel    = ~slave_select_enable | ~f_r[0];
  assign s_edge = ~mst & on & sel & (f_r[2] != sck_d_r);
  assign e_lead  = mst ? (tick & (sck_o == clock_polarity))
                       : (s_edge & (sck_d_r == clock_polarity));
  assign e_trail = mst ? (tick & (sck_o != clock_polarity))
                       : (s_edge & (sck_d_r != clock_polarity));
  assign start  = ~mst & ~busy_r & e_lead;
  assign act    = busy_r | start;
  assign e_launch = act & (cke ? e_trail : e_lead);
  assign e_mid    = act & (cke ? e_lead : e_trail);
  // Late sampling only for a master; a slave always samples mid time
  assign sample = (mst & ctrl_r[C_SMP])
                ? (tick & ((pend_r & e_launch) | last))
                : e_mid;
  assign done    = sample & (bit_r == nb - 6'd1);
  assign rx_word = {rsh_r[30:0], f_r[1]};
  assign rx_push = done & ~rx_full;
  assign ovf_set = done & rx_full;
  assign load    = on & ~busy_r & ~loaded_r & ~tx_empty;
  assign mstart  = on & mst & ~busy_r & loaded_r;
  assign ld_word = tx_mem[tx_rp_r] << (6'd32 - nb);

  // ****************
  // Pin synchroniser
  // ****************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r    <= SYNC_RST;
      s2_r    <= SYNC_RST;
      s3_r    <= SYNC_RST;
      f_r     <= SYNC_RST;
      sck_d_r <= 1'b0;
    end else begin
      s1_r    <= {sck_i, sdi_i, ss_i};
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      f_r     <= (f_r & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
      sck_d_r <= f_r[2];
    end
  end

  // ****************
  // Registers
  // ****************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
      baud_r <= BAUD_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= pwdata & CTRL_MASK;
        if (on)
          ctrl_r[C_ENH] <= ctrl_r[C_ENH];
      end
      if (acc && pwrite && paddr == BAUD_OFS)
        baud_r <= pwdata[8:0];
    end
  end

  // Overflow: hardware set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ovf_r <= 1'b0;
    else if (ovf_set)
      ovf_r <= 1'b1;
    else if (wr_stat && !pwdata[S_ROV])
      ovf_r <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tur_r <= 1'b0;
    else if (!on)
      tur_r <= 1'b0;
    else if (start && frm && !loaded_r)
      tur_r <= 1'b1;
  end

  // ****************
  // FIFO storage
  // ****************
  always_ff @(posedge pclk) begin
    if (tx_push)
      tx_mem[tx_wp_r] <= pwdata;
    if (rx_push)
      rx_mem[rx_wp_r] <= rx_word & mask_f(nb);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_wp_r <= '0;
      tx_rp_r <= '0;
      rx_wp_r <= '0;
      rx_rp_r <= '0;
    end else if (!on) begin
      tx_wp_r <= '0;
      tx_rp_r <= '0;
      rx_wp_r <= '0;
      rx_rp_r <= '0;
    end else begin
      if (tx_push)
        tx_wp_r <= tx_wp_r + 1'b1;
      if (load)
        tx_rp_r <= tx_rp_r + 1'b1;
      if (rx_push)
        rx_wp_r <= rx_wp_r + 1'b1;
      if (rx_pop)
        rx_rp_r <= rx_rp_r + 1'b1;
    end
  end

  // ****************
  // Shift engine
  // ****************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r   <= 1'b0;
      loaded_r <= 1'b0;
      pend_r   <= 1'b0;
      sr_r     <= '0;
      rsh_r    <= '0;
      bit_r    <= '0;
      half_r   <= '0;
      div_r    <= '0;
      sck_o    <= 1'b0;
      sdo_o    <= 1'b0;
    end else if (!on) begin
      busy_r   <= 1'b0;
      loaded_r <= 1'b0;
      pend_r   <= 1'b0;
      bit_r    <= '0;
      sck_o    <= clock_polarity;
    end else begin
      if (load) begin
        loaded_r <= 1'b1;
        sr_r     <= cke ? (ld_word << 1) : ld_word;
        if (cke)
          sdo_o <= ld_word[31];
      end
      if (mstart) begin
        busy_r <= 1'b1;
        half_r <= '0;
        bit_r  <= '0;
        div_r  <= baud_r;
      end
      if (start)
        busy_r <= 1'b1;
      if (!busy_r)
        sck_o <= clock_polarity;
      if (tick) begin
        sck_o  <= ~sck_o;
        half_r <= half_r + 7'd1;
        div_r  <= baud_r;
      end else if (mst && busy_r)
        div_r <= div_r - 9'd1;
      if (e_launch) begin
        sdo_o <= sr_r[31];
        sr_r  <= sr_r << 1;
      end
      if (e_mid)
        pend_r <= 1'b1;
      if (sample) begin
        pend_r <= 1'b0;
        rsh_r  <= rx_word;
        bit_r  <= bit_r + 6'd1;
      end
      // A master runs its clock out to the final idle edge
      if (done)
        bit_r <= '0;
      if (last || (done && !mst)) begin
        busy_r   <= 1'b0;
        loaded_r <= 1'b0;
      end
      if (!mst && busy_r && slave_select_enable && f_r[0]) begin
        busy_r   <= 1'b0;
        loaded_r <= 1'b0;
        bit_r    <= '0;
      end
    end
  end

  // ****************
  // Pin controls
  // ****************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_oe_n <= 1'b1;
      ss_oe_n  <= 1'b1;
      ss_o     <= 1'b1;
    end else begin
      sck_oe_n <= ~(on & mst);
      ss_oe_n  <= ~(on & mst & frm);
      ss_o     <= ~(mst & frm & busy_r & half_r == '0);
    end
  end

  // ****************
  // Interrupt levels
  // ****************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
    end else begin
      unique case (ctrl_r[C_TXS +: 2])
        2'b11: tx_irq <= on & ~tx_full;
        2'b10: tx_irq <= on & (tx_free >= (cap >> 1));
        2'b01: tx_irq <= on & tx_empty;
        2'b00: tx_irq <= on & tx_empty & ~busy_r & ~loaded_r;
      endcase
      unique case (ctrl_r[C_RXS +: 2])
        2'b11: rx_irq <= on & rx_full;
        2'b10: rx_irq <= on & ((AW+1)'(rx_cnt) >= (cap >> 1));
        2'b01: rx_irq <= on & ~rx_empty;
        2'b00: rx_irq <= on & rx_empty;
      endcase
    end
  end

  // ****************
  // Status and read
  // ****************
  always_comb begin
    stat = '0;
    stat[S_RXC +: 5] = 5'(rx_cnt);
    stat[S_TXC +: 5] = 5'(tx_cnt);
    stat[S_BUSY] = busy_r | loaded_r & mst;
    stat[S_TUR]  = tur_r;
    stat[S_SHIFTER_EMPTY_FLAG] = ~busy_r & ~loaded_r;
    stat[S_ROV]  = ovf_r;
    stat[S_RBE]  = rx_empty;
    stat[S_TBE]  = tx_empty;
    stat[S_TBF]  = tx_full;
    stat[S_RBF]  = rx_full;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr != CTRL_OFS)
               & (paddr != STAT_OFS) & (paddr != DATA_OFS)
               & (paddr != BAUD_OFS);
      if (psel && !penable) begin
        unique case (paddr)
          CTRL_OFS: prdata <= ctrl_r;
          STAT_OFS: prdata <= stat;
          DATA_OFS: prdata <= rx_empty ? '0 : rx_mem[rx_rp_r];
          BAUD_OFS: prdata <= {23'h0, baud_r};
          default:  prdata <= '0;
        endcase
      end
    end
  end

  // ****************
  // Assertions
  // ****************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_idle_clk;
    on && mst && !busy_r ##1 on && mst && !busy_r |-> sck_o == clock_polarity;
  endproperty
  a_idle_clk: assert property (p_idle_clk)
    else $error("master clock not at idle level");

  property p_oe;
    ##1 on && $stable(on) && $stable(mst) |-> sck_oe_n == !mst;
  endproperty
  a_oe: assert property (p_oe)
    else $error("clock drive does not follow master enable");

  property p_ovf;
    ovf_set |=> ovf_r ##1 (ovf_r || $past(wr_stat));
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow flag not held");

  property p_tur;
    tur_r && on |=> tur_r;
  endproperty
  a_tur: assert property (p_tur)
    else $error("underrun cleared while enabled");

  property p_tbf_std;
    on && !enh && tx_push |=> stat[S_TBF] && !stat[S_TBE];
  endproperty
  a_tbf_std: assert property (p_tbf_std)
    else $error("transmit full not set by write");

  property p_rbf_enh;
    enh |-> stat[S_RBF] == (rx_cnt == AW'(DEPTH - 1));
  endproperty
  a_rbf_enh: assert property (p_rbf_enh)
    else $error("enhanced receive full mismatch");

  property p_rbe;
    (rx_push && !rx_pop) |=> !stat[S_RBE];
  endproperty
  a_rbe: assert property (p_rbe)
    else $error("receive empty after push");

  property p_busy;
    mstart |=> stat[S_BUSY] [*2];
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy not shown after start");

  property p_txirq;
    ctrl_r[C_TXS +: 2] == 2'b01 && on && tx_push |=> ##1 !tx_irq;
  endproperty
  a_txirq: assert property (p_txirq)
    else $error("empty interrupt kept after write");

  property p_width;
    sample |-> bit_r <= (ctrl_r[C_M32] ? 6'd31
                         : (ctrl_r[C_M16] ? 6'd15 : 6'd7));
  endproperty
  a_width: assert property (p_width)
    else $error("word ended at wrong bit count");
endmodule

// ===== core/spi_pkg.sv
// Register map, field positions and reset values of the serial unit.
// Assumes a 32-bit APB with byte addresses in paddr.
package spi_pkg;
  // ****************
  // Register offsets
  // ****************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h10;
  localparam logic [7:0] DATA_OFS = 8'h20;
  localparam logic [7:0] BAUD_OFS = 8'h30;

  // ****************
  // Control fields
  // ****************
  localparam int C_FRM  = 31;
  localparam int C_ENH  = 16;
  localparam int C_ON   = 15;
  localparam int C_M32  = 11;
  localparam int C_M16  = 10;
  localparam int C_SMP  = 9;
  localparam int C_CKE  = 8;
  localparam int C_SLAVE_SELECT_ENABLE = 7;
  localparam int C_CKP  = 6;
  localparam int C_MST  = 5;
  localparam int C_TXS  = 2;
  localparam int C_RXS  = 0;
  localparam logic [31:0] CTRL_MASK = 32'h8001_8fef;
  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;

  // ****************
  // Status fields
  // ****************
  localparam int S_RXC  = 24;
  localparam int S_TXC  = 16;
  localparam int S_BUSY = 11;
  localparam int S_TUR  = 8;
  localparam int S_SHIFTER_EMPTY_FLAG = 7;
  localparam int S_ROV  = 6;
  localparam int S_RBE  = 5;
  localparam int S_TBE  = 3;
  localparam int S_TBF  = 1;
  localparam int S_RBF  = 0;

  localparam logic [8:0] BAUD_RST = 9'h000;
  // Synchroniser reset: sck low, sdi low, select high
  localparam logic [2:0] SYNC_RST = 3'b001;
endpackage

// ===== verif/spi_peer.sv
// Serial peer: answers the unit's master clock, or clocks its slave side.
// Assumes the bench routes the shared sck line and the unit's sdo.
`timescale 1ns/10ps
module spi_peer (
  input  wire logic sck,
  input  wire logic sck_oe_n,
  input  wire logic sdo,
  input  wire logic cpol,
  output logic      sdi,
  output logic      sck_drv,
  output logic      ss_n
);
  logic [7:0] out_r;
  logic [7:0] got_r;

  initial begin
    sdi     = 1'b0;
    sck_drv = 1'b0;
    ss_n    = 1'b1;
    out_r   = 8'h00;
    got_r   = 8'h00;
  end

  // ****************
  // Slave role
  // ****************
  task automatic arm(input logic [7:0] v);
    out_r = v;
    sdi   = v[7];
  endtask

  // Capture on leading edge, next bit on trailing edge
  always @(sck) begin
    if (!sck_oe_n && sck !== cpol) begin
      got_r = {got_r[6:0], sdo};
    end else if (!sck_oe_n) begin
      out_r = {out_r[6:0], ~out_r[7]};
      sdi   = out_r[7];
    end
  end

  // ****************
  // Master role
  // ****************
  // 80 ns link clock, only within the frame
  task automatic drive(input logic [7:0] v);
    ss_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sdi = v[i];
      #40 sck_drv = 1'b1;
      #40 sck_drv = 1'b0;
    end
    #40 ss_n = 1'b1;
    sdi = ~sdi;
  endtask
endmodule

// ===== verif/testbench.sv
// Self-checking bench of the serial unit over APB.
// Assumes the peer model in spi_peer.sv.
`timescale 1ns/10ps
module testbench import spi_pkg::*;;
  localparam int DEPTH = 16;
  localparam logic [31:0] B_ON = 32'h1 << C_ON;
  localparam logic [31:0] B_MS = 32'h1 << C_MST;
  localparam logic [31:0] B_CE = 32'h1 << C_CKE;
  localparam logic [31:0] B_EN = 32'h1 << C_ENH;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sck_o;
  logic        sck_oe_n;
  logic        sdi;
  logic        sdo_o;
  logic        ss_o;
  logic        ss_oe_n;
  logic        tx_irq;
  logic        rx_irq;
  logic        peer_sck;
  logic        peer_ss_n;
  logic        cpol;
  logic        sck_line;
  logic        ss_line;
  logic [31:0] q;
  logic        err;
  int          mismatches;
  int          checks_done;
  int          cycles;

  assign sck_line = sck_oe_n ? peer_sck : sck_o;
  assign ss_line  = ss_oe_n ? peer_ss_n : ss_o;

  serial_unit #(.DEPTH(DEPTH)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sck_i(sck_line),
    .sck_o(sck_o), .sck_oe_n(sck_oe_n), .sdi_i(sdi), .sdo_o(sdo_o),
    .ss_i(ss_line), .ss_o(ss_o), .ss_oe_n(ss_oe_n), .tx_irq(tx_irq),
    .rx_irq(rx_irq)
  );

  spi_peer peer (
    .sck(sck_line), .sck_oe_n(sck_oe_n), .sdo(sdo_o), .cpol(cpol),
    .sdi(sdi), .sck_drv(peer_sck), .ss_n(peer_ss_n)
  );

  always #2.5 pclk = ~pclk;

  // ****************
  // Shared tasks
  // ****************
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Unit off twice, so the buffer mode bit also clears
  task automatic off;
    apb(1'b1, CTRL_OFS, 32'h0);
    apb(1'b1, CTRL_OFS, 32'h0);
  endtask

  task automatic xfer(input logic [7:0] tx, input logic [7:0] rx);
    peer.arm(rx);
    apb(1'b1, DATA_OFS, {24'h0, tx});
    // Load and start take two cycles after the write
    apb(1'b0, STAT_OFS, 32'h0);
    apb(1'b0, STAT_OFS, 32'h0);
    check("busy", 1, q[S_BUSY]);
    while (q[S_BUSY] !== 1'b0) apb(1'b0, STAT_OFS, 32'h0);
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_reset;
    apb(1'b0, STAT_OFS, 32'h0);
    check("stat reset", 32'ha8, q);
    apb(1'b1, STAT_OFS, 32'hffff_ffff);
    apb(1'b1, DATA_OFS, 32'h5a);
    apb(1'b0, STAT_OFS, 32'h0);
    check("stat kept", 32'ha8, q);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped err", 1, err);
    apb(1'b1, CTRL_OFS, 32'hffff_ffff);
    apb(1'b0, CTRL_OFS, 32'h0);
    check("ctrl mask", CTRL_MASK, q);
    apb(1'b1, CTRL_OFS, 32'h0);
    apb(1'b0, CTRL_OFS, 32'h0);
    check("buffer bit kept", B_EN, q);
    off();
  endtask

  task automatic t_master;
    cpol = 1'b1;
    apb(1'b1, BAUD_OFS, 32'd7);
    apb(1'b1, CTRL_OFS, B_ON | B_MS | B_CE | (32'h1 << C_CKP) | 32'h4);
    repeat (2) @(negedge pclk);
    check("sck idle", 1, sck_o);
    check("sck driven", 0, sck_oe_n);
    xfer(8'ha5, 8'h3c);
    check("peer word", 8'ha5, peer.got_r);
    check("tx irq", 1, tx_irq);
    apb(1'b0, STAT_OFS, 32'h0);
    check("flags", 32'h9, q & 32'h80b);
    apb(1'b0, DATA_OFS, 32'h0);
    check("rx word", 32'h3c, q);
    apb(1'b0, STAT_OFS, 32'h0);
    check("rx full clr", 0, q[S_RBF]);
    apb(1'b1, CTRL_OFS, B_ON | B_MS | B_CE | (32'h1 << C_CKP)
        | (32'h1 << C_SMP) | 32'h4);
    xfer(8'h5a, 8'hc3);
    check("peer word late", 8'h5a, peer.got_r);
    apb(1'b0, DATA_OFS, 32'h0);
    check("late sample", 32'hc3, q);
  endtask

  task automatic t_fifo;
    off();
    cpol = 1'b0;
    apb(1'b1, CTRL_OFS, B_EN | B_MS | B_CE | 32'h3);
    apb(1'b1, CTRL_OFS, B_EN | B_ON | B_MS | B_CE | 32'h3);
    for (int i = 1; i < DEPTH; i++) begin
      xfer(8'(i), 8'(i + 64));
    end
    apb(1'b0, STAT_OFS, 32'h0);
    check("rx count", 32'(DEPTH - 1), {27'h0, q[28:24]});
    check("rx full", 1, q[S_RBF]);
    check("rx irq full", 1, rx_irq);
    xfer(8'h00, 8'hee);
    for (int i = 1; i < DEPTH; i++) begin
      apb(1'b0, DATA_OFS, 32'h0);
      check("fifo word", 32'(i + 64), q);
    end
    apb(1'b0, STAT_OFS, 32'h0);
    check("drained", 32'he8, q);
    apb(1'b1, STAT_OFS, 32'h0);
    apb(1'b0, STAT_OFS, 32'h0);
    check("ovf clear", 32'ha8, q);
    apb(1'b1, CTRL_OFS, B_EN | B_ON | B_MS | B_CE | 32'h8);
    apb(1'b0, STAT_OFS, 32'h0);
    check("tx irq half", 1, tx_irq);
    check("rx irq empty", 1, rx_irq);
  endtask

  task automatic t_slave;
    off();
    apb(1'b1, CTRL_OFS, B_ON | (32'h1 << C_SLAVE_SELECT_ENABLE) | B_CE | (32'h1 << C_SMP)
        | 32'h1);
    check("slave sck", 1, sck_oe_n);
    peer.drive(8'h96);
    apb(1'b0, STAT_OFS, 32'h0);
    check("slave full", 1, q[S_RBF]);
    check("rx irq", 1, rx_irq);
    apb(1'b0, DATA_OFS, 32'h0);
    check("slave word", 32'h96, q);
  endtask

  task automatic t_framed;
    off();
    apb(1'b1, CTRL_OFS, (32'h1 << C_FRM) | B_ON);
    peer.drive(8'h5a);
    apb(1'b0, STAT_OFS, 32'h0);
    check("underrun", 1, q[S_TUR]);
    off();
    apb(1'b1, CTRL_OFS, (32'h1 << C_FRM) | B_ON);
    apb(1'b0, STAT_OFS, 32'h0);
    check("underrun clr", 0, q[S_TUR]);
    apb(1'b1, CTRL_OFS, (32'h1 << C_FRM) | B_ON | B_MS);
    apb(1'b0, STAT_OFS, 32'h0);
    check("frame drive", 0, ss_oe_n);
    check("frame idle", 1, ss_o);
    off();
  endtask

  initial begin
    pclk        = 1'b0;
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0;
    cpol        = 1'b0;
    mismatches  = 0;
    checks_done = 0;
    cycles      = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_master();
    t_fifo();
    t_slave();
    t_framed();
    final_report();
  end
endmodule
